// ### hdl/fpstc_core.sv
/*
 fpstc_core: floating-point state register with rounding and flush control,
 trap-type tracking, accrued/current exception update and unfinished detection.
 assumes: pipeline inputs are on ref_clk; at most one of op, load, store per cycle
 is intended, op wins over load, an op's trap wins over a store's clear.
*/
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - rounding field codes 0 nearest-even, 1 toward zero, 2 plus, 3 minus infinity.
// - interval mode set means graphics rounding field replaces state rounding field.
// - bits 27..23 enable traps per exception; any enabled raised exception traps.
// - nonstandard mode flushes subnormal source operands to signed zero, no exception.
// - nonstandard mode flushes subnormal results to signed zero silently here.
// - interval mode set makes the nonstandard bit act as cleared.
// - bits 19..17 hold fixed version; loads never change it.
// - version 7 only when no hardware unit exists.
// - trap cause written into bits 16..14, held until store or operate.
// - 32- and 64-bit loads leave trap type untouched.
// - completed store clears trap type; failed store leaves it.
// - a non-trapping operate clears trap type.
// - codes 0 none, 1 IEEE, 2 unfinished, 3 unimplemented; 7 reserved.
// - codes 4, 5 and 6 are never produced.
// - any trap leaves accrued exceptions unchanged.
// - trap keeps current exceptions, IEEE trap sets only the trapping bit.
// - trapping operation writes no destination; sources stay as they were.
// - trapping operation leaves all four condition-code fields unchanged.
// - double-to-single traps unfinished when -25 < result exponent < 1.
// - single-to-double traps unfinished on a denormal operand.
// - add/subtract traps unfinished on denormal operands or result exponent below 1.
// - without other trap, enabled current exceptions trap, else accrue into aexc.
// - every quad operate traps unimplemented, current exceptions unchanged.
module fpstc_core #(
   parameter logic [2:0] FP_VERSION = 3'h0 // arbitrary value, never VER_NO_FPU
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic op_valid,
   input wire fpstc_pkg::fpstc_op_t op_class,
   input wire logic [4:0] op_cexc,
   input wire logic src1_denorm,
   input wire logic src1_normal,
   input wire logic src2_denorm,
   input wire logic src2_normal,
   input wire logic signed [12:0] res_exp,
   input wire logic [1:0] cmp_sel,
   input wire logic [1:0] cmp_value,
   input wire logic state_load_32,
   input wire logic state_load_64,
   input wire logic [63:0] load_data,
   input wire logic state_store_ok,
   input wire logic interval_mode_bit,
   input wire logic [1:0] graphics_rounding_field,
   output logic [63:0] state_read_data,
   output logic [1:0] round_mode,
   output logic flush_zero,
   output logic trap_ieee,
   output logic trap_other,
   output logic result_commit
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] rd;
      logic [4:0] trap_enable_mask;
      logic ns;
      logic [2:0] ftt;
      logic [7:0] fcc;
      logic [4:0] aexc;
      logic [4:0] cexc;
      logic [1:0] rnd_out;
      logic flush_out;
      logic trap_ieee;
      logic trap_other;
      logic commit;
      logic [63:0] rdata;
   } fpstc_state_t;

   fpstc_state_t state_reg;
   fpstc_state_t state_next;
   logic ns_eff;
   logic unfinished;
   logic [4:0] ieee_hit;
   logic [4:0] ieee_bit;

   // highest-numbered enabled exception gets the single cexc bit
   function automatic logic [4:0] pick_one(input logic [4:0] hits);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < fpstc_pkg::EXC_W; i++) begin
         if (hits[i]) begin
            r = 5'h00;
            r[i] = 1'b1;
         end
      end
      return r;
   endfunction : pick_one

   // assemble the software-visible register image
   function automatic logic [63:0] image(input fpstc_state_t s);
      logic [63:0] v;
      v = 64'h0; // reserved bits and queue-not-empty read zero
      v[fpstc_pkg::RD_LSB +: 2] = s.rd;
      v[fpstc_pkg::TEM_LSB +: 5] = s.trap_enable_mask;
      v[fpstc_pkg::NS_BIT] = s.ns;
      v[fpstc_pkg::VER_LSB +: 3] = FP_VERSION;
      v[fpstc_pkg::FTT_LSB +: 3] = s.ftt;
      v[fpstc_pkg::FCC0_LSB +: 2] = s.fcc[1:0];
      v[fpstc_pkg::FCC1_LSB +: 6] = s.fcc[7:2];
      v[fpstc_pkg::AEXC_LSB +: 5] = s.aexc;
      v[fpstc_pkg::CEXC_LSB +: 5] = s.cexc;
      return v;
   endfunction : image

   // ---------------------------------------------------------------
   // operation decode
   // ---------------------------------------------------------------
   // interval mode overrides nonstandard mode
   assign ns_eff = state_reg.ns & ~interval_mode_bit;
   assign ieee_hit = op_cexc & state_reg.trap_enable_mask;
   assign ieee_bit = pick_one(ieee_hit);

   // unfinished detection; flushed operands and results never reach it
   always_comb begin
      unfinished = 1'b0;
      unique case (op_class)
         fpstc_pkg::FOP_D2S: unfinished = ~ns_eff & (res_exp > fpstc_pkg::EXP_D2S_LO)
            & (res_exp < fpstc_pkg::EXP_UNF_HI);
         fpstc_pkg::FOP_S2D: unfinished = ~ns_eff & src1_denorm;
         fpstc_pkg::FOP_ADDSUB: unfinished = ~ns_eff & ((src1_denorm & src2_denorm)
            | (src1_denorm & src2_normal) | (src2_denorm & src1_normal)
            | (res_exp < fpstc_pkg::EXP_UNF_HI));
         default: unfinished = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.trap_ieee = 1'b0;
      state_next.trap_other = 1'b0;
      state_next.commit = 1'b0;
      if (op_valid) begin
         if (op_class == fpstc_pkg::FOP_QUAD) begin
            state_next.ftt = fpstc_pkg::FTT_UNIMPLEMENTED;
            state_next.trap_other = 1'b1;
         end else if (unfinished) begin
            state_next.ftt = fpstc_pkg::FTT_UNFINISHED;
            state_next.trap_other = 1'b1;
         end else if (|ieee_hit) begin
            state_next.ftt = fpstc_pkg::FTT_IEEE;
            state_next.cexc = state_reg.cexc | ieee_bit;
            state_next.trap_ieee = 1'b1;
         end else begin
            state_next.ftt = fpstc_pkg::FTT_NONE;
            state_next.cexc = op_cexc;
            state_next.aexc = state_reg.aexc | op_cexc;
            state_next.commit = 1'b1;
            if (op_class == fpstc_pkg::FOP_CMP) begin
               state_next.fcc[cmp_sel*2 +: 2] = cmp_value;
            end
         end
      end else if (state_load_32 || state_load_64) begin
         // loads never touch ftt or version
         state_next.rd = load_data[fpstc_pkg::RD_LSB +: 2];
         state_next.trap_enable_mask = load_data[fpstc_pkg::TEM_LSB +: 5];
         state_next.ns = load_data[fpstc_pkg::NS_BIT];
         state_next.fcc[1:0] = load_data[fpstc_pkg::FCC0_LSB +: 2];
         state_next.aexc = load_data[fpstc_pkg::AEXC_LSB +: 5];
         state_next.cexc = load_data[fpstc_pkg::CEXC_LSB +: 5];
         if (state_load_64) begin
            state_next.fcc[7:2] = load_data[fpstc_pkg::FCC1_LSB +: 6];
         end
      end
      // a completed store clears ftt; a same-cycle trap wins
      if (state_store_ok && !op_valid) begin
         state_next.ftt = fpstc_pkg::FTT_NONE;
      end
      // effective rounding and flush controls for the datapath
      state_next.rnd_out = interval_mode_bit ? graphics_rounding_field
         : state_reg.rd;
      state_next.flush_out = ns_eff;
      state_next.rdata = image(state_next);
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign state_read_data = state_reg.rdata;
   assign round_mode = state_reg.rnd_out;
   assign flush_zero = state_reg.flush_out;
   assign trap_ieee = state_reg.trap_ieee;
   assign trap_other = state_reg.trap_other;
   assign result_commit = state_reg.commit;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   chk_round_select: assert property (
      ##1 round_mode == ($past(interval_mode_bit) ? $past(graphics_rounding_field)
         : $past(state_reg.rd)))
      else $error("rounding mode source wrong");
   chk_flush_interval: assert property (
      interval_mode_bit |=> !flush_zero)
      else $error("flush active under interval mode");
   chk_ieee_trap: assert property (
      op_valid && op_class != fpstc_pkg::FOP_QUAD && !unfinished && |(op_cexc & state_reg.trap_enable_mask)
      |=> trap_ieee && !trap_other && state_reg.ftt == fpstc_pkg::FTT_IEEE)
      else $error("enabled exception did not trap");
   chk_version_fixed: assert property (
      state_load_64 |=> state_read_data[fpstc_pkg::VER_LSB +: 3] == FP_VERSION)
      else $error("version field changed");
   chk_version_legal: assert property (
      FP_VERSION != fpstc_pkg::VER_NO_FPU)
      else $error("version claims no hardware unit");
   chk_load_keeps_ftt: assert property (
      (state_load_32 || state_load_64) && !op_valid && !state_store_ok
      |=> $stable(state_reg.ftt))
      else $error("load changed trap type");
   chk_store_clears: assert property (
      state_store_ok && !op_valid |=> state_reg.ftt == fpstc_pkg::FTT_NONE)
      else $error("store did not clear trap type");
   chk_ftt_legal: assert property (
      state_reg.ftt < fpstc_pkg::FTT_FIRST_ILLEGAL)
      else $error("illegal trap type");
   chk_trap_aexc: assert property (
      trap_ieee || trap_other |-> state_reg.aexc == $past(state_reg.aexc)
         && state_reg.fcc == $past(state_reg.fcc))
      else $error("trap altered accrued or condition codes");
   chk_trap_commit: assert property (
      op_valid ##1 (trap_ieee || trap_other) |-> !result_commit)
      else $error("trapping op committed");
   chk_quad_unimpl: assert property (
      op_valid && op_class == fpstc_pkg::FOP_QUAD |=> trap_other
         && state_reg.ftt == fpstc_pkg::FTT_UNIMPLEMENTED && $stable(state_reg.cexc))
      else $error("quad op not unimplemented");
   chk_clean_op: assert property (
      op_valid ##1 !(trap_ieee || trap_other) |-> result_commit
         && state_reg.ftt == fpstc_pkg::FTT_NONE)
      else $error("clean op left trap type");
   chk_unfinished_trap: assert property (
      op_valid && op_class == fpstc_pkg::FOP_ADDSUB && !ns_eff && src1_denorm && src2_denorm
      |=> trap_other && state_reg.ftt == fpstc_pkg::FTT_UNFINISHED)
      else $error("denormal add did not trap");
   // trap vectors, trap-type codes and exclusivity of the three pulses
   chk_ieee_vector: assert property (
      trap_ieee |-> state_reg.ftt == fpstc_pkg::FTT_IEEE)
      else $error("IEEE trap with wrong trap type");
   chk_other_vector: assert property (
      trap_other |-> state_reg.ftt == fpstc_pkg::FTT_UNFINISHED
         || state_reg.ftt == fpstc_pkg::FTT_UNIMPLEMENTED)
      else $error("other trap with wrong trap type");
   chk_pulse_exclusive: assert property (
      !(trap_ieee && trap_other) && !(result_commit && (trap_ieee || trap_other)))
      else $error("trap and commit pulses overlap");
   chk_trap_sets_ftt: assert property (
      trap_ieee || trap_other |-> state_reg.ftt != fpstc_pkg::FTT_NONE)
      else $error("trap signalled with trap type zero");
   // exception fields around traps and clean operations
   chk_other_keeps_cexc: assert property (
      trap_other |-> $stable(state_reg.cexc))
      else $error("other trap altered current exceptions");
   chk_ieee_one_bit: assert property (
      trap_ieee |-> $countones(state_reg.cexc ^ $past(state_reg.cexc)) <= 1
         && ($past(state_reg.cexc) & ~state_reg.cexc) == 5'h00)
      else $error("IEEE trap changed more than one exception bit");
   chk_clean_accrue: assert property (
      op_valid && op_class != fpstc_pkg::FOP_QUAD && !unfinished
         && !(|(op_cexc & state_reg.trap_enable_mask))
      |=> state_reg.aexc == ($past(state_reg.aexc) | $past(op_cexc))
         && state_reg.cexc == $past(op_cexc))
      else $error("clean op did not accrue exceptions");
   // unfinished conversions and the flush control
   chk_d2s_unfinished: assert property (
      op_valid && op_class == fpstc_pkg::FOP_D2S && !ns_eff
         && res_exp > fpstc_pkg::EXP_D2S_LO && res_exp < fpstc_pkg::EXP_UNF_HI
      |=> trap_other && state_reg.ftt == fpstc_pkg::FTT_UNFINISHED)
      else $error("narrowing conversion did not trap");
   chk_s2d_unfinished: assert property (
      op_valid && op_class == fpstc_pkg::FOP_S2D && !ns_eff && src1_denorm
      |=> trap_other && state_reg.ftt == fpstc_pkg::FTT_UNFINISHED)
      else $error("widening conversion of denormal did not trap");
   chk_flush_follows: assert property (
      !interval_mode_bit |=> flush_zero == $past(state_reg.ns))
      else $error("flush control does not follow nonstandard bit");

   cov_ieee_trap: cover property (op_valid ##1 trap_ieee);
   cov_unfinished: cover property (op_valid && unfinished ##1 trap_other);
   cov_load_64: cover property (state_load_64 && !op_valid);
   cov_trap_then_store: cover property (trap_ieee ##[1:8] state_store_ok);
   cov_quad: cover property (op_valid && op_class == fpstc_pkg::FOP_QUAD ##1 trap_other);
endmodule : fpstc_core
`default_nettype wire

// ### hdl/fpstc_pkg.sv
/*
 fpstc_pkg: field positions, codes and limits of the floating-point state register.
 assumes: used by fpstc_core only through fpstc_pkg::name.
*/
package fpstc_pkg;
   // ---------------------------------------------------------------
   // field positions of the 64-bit state register
   // ---------------------------------------------------------------
   localparam int RD_LSB = 30;
   localparam int TEM_LSB = 23;
   localparam int NS_BIT = 22;
   localparam int VER_LSB = 17;
   localparam int FTT_LSB = 14;
   localparam int QNE_BIT = 13;
   localparam int FCC0_LSB = 10;
   localparam int AEXC_LSB = 5;
   localparam int CEXC_LSB = 0;
   localparam int FCC1_LSB = 32;
   localparam int EXC_W = 5;
   // ---------------------------------------------------------------
   // trap-type codes
   // ---------------------------------------------------------------
   localparam logic [2:0] FTT_NONE = 3'h0;
   localparam logic [2:0] FTT_IEEE = 3'h1;
   localparam logic [2:0] FTT_UNFINISHED = 3'h2;
   localparam logic [2:0] FTT_UNIMPLEMENTED = 3'h3;
   localparam logic [2:0] FTT_FIRST_ILLEGAL = 3'h4;
   // version 7 means no hardware unit at all
   localparam logic [2:0] VER_NO_FPU = 3'h7;
   // ---------------------------------------------------------------
   // rounding directions
   // ---------------------------------------------------------------
   localparam logic [1:0] RND_NEAREST = 2'h0;
   localparam logic [1:0] RND_ZERO = 2'h1;
   localparam logic [1:0] RND_PLUS_INF = 2'h2;
   localparam logic [1:0] RND_MINUS_INF = 2'h3;
   // ---------------------------------------------------------------
   // exponent limits for unfinished-operation detection
   // ---------------------------------------------------------------
   localparam int EXP_W = 13;
   localparam logic signed [EXP_W-1:0] EXP_D2S_LO = -13'sd25;
   localparam logic signed [EXP_W-1:0] EXP_UNF_HI = 13'sd1;
   // operation classes from the issue stage
   typedef enum logic [2:0] {
      FOP_OTHER, FOP_ADDSUB, FOP_D2S, FOP_S2D, FOP_QUAD, FOP_CMP
   } fpstc_op_t;
endpackage : fpstc_pkg

// ### verification/fp_state_trap_control_tb_top.sv
/*
 fp_state_trap_control_tb_top: directed bench for fpstc_core.
 assumes: inputs change at falling ref_clk, outputs settle one edge later.
*/
`timescale 1ns/10ps
`default_nettype none
module fp_state_trap_control_tb_top;
   logic ref_clk, rst_n, op_valid, src1_denorm, src1_normal, src2_denorm, src2_normal;
   logic state_load_32, state_load_64, state_store_ok, interval_mode_bit;
   logic [4:0] op_cexc;
   logic [1:0] cmp_sel, cmp_value, graphics_rounding_field, round_mode;
   logic signed [12:0] res_exp;
   logic [63:0] load_data, d;
   logic flush_zero, trap_ieee, trap_other, result_commit, clash;
   logic [7:0] n_trap;
   fpstc_pkg::fpstc_op_t op_class;
   int fail_count, n_compared, cyc;
   localparam logic [63:0] BASE = 64'h0000_003F_000F_CD44; // ver/ftt bits set on purpose
   fpstc_pkg::fpstc_op_t tc [10] = '{fpstc_pkg::FOP_ADDSUB, fpstc_pkg::FOP_ADDSUB,
      fpstc_pkg::FOP_ADDSUB, fpstc_pkg::FOP_ADDSUB, fpstc_pkg::FOP_D2S, fpstc_pkg::FOP_D2S,
      fpstc_pkg::FOP_D2S, fpstc_pkg::FOP_S2D, fpstc_pkg::FOP_S2D, fpstc_pkg::FOP_QUAD};
   logic [3:0] tk [10] = '{4'hA, 4'h9, 4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'h8, 4'h4, 4'h5};
   logic signed [12:0] te [10] = '{5, 5, 0, 1, -24, -25, 1, 5, 5, 5};
   logic [2:0] tf [10] = '{3'h2, 3'h2, 3'h2, 3'h0, 3'h2, 3'h0, 3'h0, 3'h2, 3'h0, 3'h3};

   fpstc_core #(.FP_VERSION(3'h5)) fpstc_core_i (.ref_clk(ref_clk), .rst_n(rst_n),
      .op_valid(op_valid), .op_class(op_class), .op_cexc(op_cexc),
      .src1_denorm(src1_denorm), .src1_normal(src1_normal), .src2_denorm(src2_denorm),
      .src2_normal(src2_normal), .res_exp(res_exp), .cmp_sel(cmp_sel), .cmp_value(cmp_value),
      .state_load_32(state_load_32), .state_load_64(state_load_64), .load_data(load_data),
      .state_store_ok(state_store_ok), .interval_mode_bit(interval_mode_bit),
      .graphics_rounding_field(graphics_rounding_field), .state_read_data(d),
      .round_mode(round_mode), .flush_zero(flush_zero), .trap_ieee(trap_ieee),
      .trap_other(trap_other), .result_commit(result_commit));
   fpstc_trap_sink fpstc_trap_sink_i (.ref_clk(ref_clk), .rst_n(rst_n), .trap_ieee(trap_ieee),
      .trap_other(trap_other), .result_commit(result_commit), .n_trap(n_trap), .clash(clash));

   // ----------------------------------------------------------------
   // clock, timeout and shared tasks
   // ----------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         test_done();
      end
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   // one operate completing, outputs sampled after its edge
   task automatic op(input fpstc_pkg::fpstc_op_t c, input logic [4:0] x, input logic [3:0] k,
         input logic signed [12:0] e);
      @(negedge ref_clk);
      op_valid = 1'b1;
      op_class = c;
      op_cexc = x;
      res_exp = e;
      {src1_denorm, src1_normal, src2_denorm, src2_normal} = k;
      @(negedge ref_clk);
      op_valid = 1'b0;
   endtask : op
   // register load, w selects the 64-bit form
   task automatic ld(input logic w, input logic [63:0] v);
      @(negedge ref_clk);
      {state_load_64, state_load_32, load_data} = {w, !w, v};
      @(negedge ref_clk);
      {state_load_64, state_load_32} = 2'h0;
   endtask : ld
   task automatic st();
      @(negedge ref_clk);
      state_store_ok = 1'b1;
      @(negedge ref_clk);
      state_store_ok = 1'b0;
   endtask : st
   task automatic test_done();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      {rst_n, op_valid, state_load_32, state_load_64, state_store_ok, interval_mode_bit} = 6'h00;
      {op_cexc, cmp_sel, cmp_value, graphics_rounding_field, res_exp, load_data} = '0;
      {src1_denorm, src1_normal, src2_denorm, src2_normal} = 4'h0;
      op_class = fpstc_pkg::FOP_OTHER;
      repeat (3) @(negedge ref_clk);
      rst_n = 1'b1;
      @(negedge ref_clk);
      chk(d[19:17], 3'h5);
      chk(d[16:14], fpstc_pkg::FTT_NONE);
      // rounding codes through 32-bit loads
      for (int r = 0; r < 4; r++) begin
         ld(1'b0, {32'h0000_0000, r[1:0], 30'h0000_0C00});
         @(negedge ref_clk);
         chk(round_mode, r[1:0]);
      end
      $display("test rounding done");
      // interval mode overrides rounding and flush
      {interval_mode_bit, graphics_rounding_field} = 3'h5;
      ld(1'b1, 64'h0000_003F_C040_0C00);
      @(negedge ref_clk);
      chk(round_mode, 2'h1);
      chk(flush_zero, 1'b0);
      interval_mode_bit = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk(flush_zero, 1'b1);
      op(fpstc_pkg::FOP_ADDSUB, 5'h00, 4'hA, 5);
      chk({trap_other, result_commit}, 2'h1);
      $display("test interval done");
      // unfinished and unimplemented table, then load keeps and store clears
      for (int i = 0; i < 10; i++) begin
         ld(1'b1, BASE);
         chk(d[19:14], {3'h5, 3'h0});
         op(tc[i], 5'h01, tk[i], te[i]);
         chk(d[16:14], tf[i]);
         chk({trap_other, trap_ieee, result_commit}, {tf[i] != 3'h0, 1'b0, tf[i] == 3'h0});
         chk(d[9:0], (tf[i] != 3'h0) ? 10'h144 : 10'h161);
         chk({d[37:32], d[11:10]}, 8'hFF);
         ld(i[0], BASE);
         chk(d[16:14], tf[i]);
         st();
         chk(d[16:14], fpstc_pkg::FTT_NONE);
      end
      $display("test unfinished done");
      // enabled exception traps, masked one accrues
      ld(1'b1, BASE | 64'h0080_0000);
      op(fpstc_pkg::FOP_OTHER, 5'h01, 4'h5, 5);
      chk({trap_ieee, trap_other, result_commit}, 3'h4);
      chk({d[16:14], d[9:0]}, {fpstc_pkg::FTT_IEEE, 10'h145});
      op(fpstc_pkg::FOP_OTHER, 5'h00, 4'h5, 5);
      chk({d[16:14], result_commit}, 4'h1);
      op(fpstc_pkg::FOP_OTHER, 5'h10, 4'h5, 5);
      chk({trap_ieee, d[9:0]}, 11'h350);
      $display("test ieee done");
      // compare writes the selected condition field
      {cmp_sel, cmp_value} = 4'h9;
      op(fpstc_pkg::FOP_CMP, 5'h00, 4'h5, 5);
      chk(d[37:32], 6'h37);
      chk({clash, n_trap}, 9'h007);
      $display("test compare done");
      test_done();
   end
endmodule : fp_state_trap_control_tb_top
`default_nettype wire

// ### verification/fpstc_trap_sink.sv
/*
 fpstc_trap_sink: trap logic stand-in, counts taken traps and flags commit clashes.
 assumes: trap and commit pulses are one ref_clk cycle wide.
*/
`timescale 1ns/10ps
`default_nettype none
module fpstc_trap_sink (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic trap_ieee,
   input wire logic trap_other,
   input wire logic result_commit,
   output logic [7:0] n_trap,
   output logic clash
);
   // count traps, flag a commit or a second vector beside a trap
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         n_trap <= 8'h00;
         clash <= 1'b0;
      end else begin
         n_trap <= n_trap + {7'h00, trap_ieee | trap_other};
         if ((result_commit | trap_ieee) & (trap_other | (result_commit & trap_ieee))) begin
            clash <= 1'b1;
         end
      end
   end
endmodule : fpstc_trap_sink
`default_nettype wire
